// ===== plc_cell.sv
/*
  Programmable logic cell: four source multiplexers, four AND gates with
  true or complement enables and output polarity, eight logic functions,
  output inversion and edge flag.
  Assumes configuration and control arrive as plain ports that software
  may change at any time; source inputs are asynchronous to clk_in.
*/
`default_nettype none
// Summary of operation
// - Four multiplexers, each picks any of 41.
// - Six-bit codes; 4 own cell output; 6,7 reserved.
// - Each gate takes any inputs, true or complemented.
// - Gate ANDs routed inputs, then optional inversion.
// - Gate with no inputs gives its polarity bit.
// - 0x55 AND, 0xAA NOR, 0x00 constant polarity.
// - Both forms of one input force zero.
// - Gates 1 to 4 use enable sets 0 to 3.
// - Eight four-input functions fed by gate outputs.
// - Output goes to peripherals, pin and feedback.
// - Output invert bit inverts the function result.
// - Polarity-caused output transitions raise the flag.
// - All settings take effect at run time.
// - Selection and gating settings have no reset.
// - Three-bit mode selects one of eight functions.
// - Enabled rising or falling output edge sets flag.
// - Disabled cell drives logic zero.
// - Reset clears control bits, sync stages, state, output and flag.
module plc_cell
  import plc_pkg::*;
#(
  parameter int SOURCES = NUM_SOURCES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [SOURCES-1:0] source_in,
  input wire logic [SEL_W-1:0] input_mux_select0_in,
  input wire logic [SEL_W-1:0] input_mux_select1_in,
  input wire logic [SEL_W-1:0] input_mux_select2_in,
  input wire logic [SEL_W-1:0] input_mux_select3_in,
  input wire logic [GATE_EN_W-1:0] gate1_input_enables_in,
  input wire logic [GATE_EN_W-1:0] gate2_input_enables_in,
  input wire logic [GATE_EN_W-1:0] gate3_input_enables_in,
  input wire logic [GATE_EN_W-1:0] gate4_input_enables_in,
  input wire logic [NUM_GATES-1:0] gate_output_invert_in,
  input wire logic cell_output_invert_in,
  input wire logic cell_enable_bit_in,
  input wire logic [2:0] function_mode_field_in,
  input wire logic rise_irq_enable_in,
  input wire logic fall_irq_enable_in,
  input wire logic cell_irq_flag_clear_in,
  output logic first_cell_output_out,
  output logic cell_irq_flag_out
);
  logic [SOURCES-1:0] sync_a, sync_b, sync_c, src_filt;
  logic [SOURCES-1:0] next_sync_a, next_sync_b, next_sync_c, next_src_filt;
  logic [SEL_W-1:0] sel [NUM_GATES];
  logic [GATE_EN_W-1:0] gate_en [NUM_GATES];
  logic [NUM_GATES-1:0] gate_pol;
  logic ctl_en, ctl_inv, ctl_rise, ctl_fall;
  logic [2:0] ctl_mode;
  logic next_ctl_en, next_ctl_inv, next_ctl_rise, next_ctl_fall;
  logic [2:0] next_ctl_mode;
  logic [NUM_GATES-1:0] data, gate;
  logic q, next_q, clk_prev, next_clk_prev;
  logic cell_out, next_cell_out, flag, next_flag;
  logic func;

  // Sources cross in through three stages; a change counts once the last two agree.
  always_comb
  begin
    next_sync_a = source_in;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_src_filt = src_filt;
    for (int i = 0; i < SOURCES; i++)
    begin
      if (sync_b[i] == sync_c[i])
      begin
        next_src_filt[i] = sync_c[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
      src_filt <= '0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
      src_filt <= next_src_filt;
    end
  end

  // Selection, gating and gate polarity are not reset and follow the ports every cycle.
  always_ff @(posedge clk_in)
  begin
    sel[0] <= input_mux_select0_in;
    sel[1] <= input_mux_select1_in;
    sel[2] <= input_mux_select2_in;
    sel[3] <= input_mux_select3_in;
    gate_en[0] <= gate1_input_enables_in;
    gate_en[1] <= gate2_input_enables_in;
    gate_en[2] <= gate3_input_enables_in;
    gate_en[3] <= gate4_input_enables_in;
    gate_pol <= gate_output_invert_in;
  end

  always_comb
  begin
    next_ctl_en = cell_enable_bit_in;
    next_ctl_inv = cell_output_invert_in;
    next_ctl_rise = rise_irq_enable_in;
    next_ctl_fall = fall_irq_enable_in;
    next_ctl_mode = function_mode_field_in;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctl_en <= CTRL_BIT_RESET;
      ctl_inv <= CTRL_BIT_RESET;
      ctl_rise <= CTRL_BIT_RESET;
      ctl_fall <= CTRL_BIT_RESET;
      ctl_mode <= MODE_RESET;
    end
    else
    begin
      ctl_en <= next_ctl_en;
      ctl_inv <= next_ctl_inv;
      ctl_rise <= next_ctl_rise;
      ctl_fall <= next_ctl_fall;
      ctl_mode <= next_ctl_mode;
    end
  end

  generate
    for (genvar g = 0; g < NUM_GATES; g++)
    begin : gen_gate
      logic term;
      always_comb
      begin
        if (sel[g] == SEL_OWN_OUTPUT)
        begin
          data[g] = cell_out;
        end
        else if (sel[g] == SEL_RESERVED_A || sel[g] == SEL_RESERVED_B || sel[g] > SEL_LAST)
        begin
          data[g] = 1'b0;
        end
        else
        begin
          data[g] = src_filt[sel[g][5:0]];
        end
      end
      always_comb
      begin
        term = 1'b1;
        for (int d = 0; d < NUM_GATES; d++)
        begin
          if (gate_en[g][2*d+GATE_TRUE_POS])
          begin
            term = term & data[d];
          end
          if (gate_en[g][2*d+GATE_COMP_POS])
          begin
            term = term & ~data[d];
          end
        end
        // An empty gate leaves the term at one, so the polarity bit alone sets the level.
        gate[g] = term ^ ~gate_pol[g];
      end
    end
  endgenerate

  // Clocked modes use gate 1 as their clock, sampled on clk_in.
  always_comb
  begin
    next_clk_prev = gate[0];
    next_q = q;
    func = q;
    case (ctl_mode)
      MODE_AND_OR: func = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      MODE_OR_XOR: func = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
      MODE_AND4: func = &gate;
      MODE_SR_LATCH:
      begin
        if (gate[2] | gate[3])
        begin
          next_q = 1'b0;
        end
        else if (gate[0] | gate[1])
        begin
          next_q = 1'b1;
        end
      end
      MODE_DFF_SR:
      begin
        if (gate[2])
        begin
          next_q = 1'b0;
        end
        else if (gate[3])
        begin
          next_q = 1'b1;
        end
        else if (gate[0] & ~clk_prev)
        begin
          next_q = gate[1];
        end
      end
      MODE_DFF2_R:
      begin
        if (gate[2])
        begin
          next_q = 1'b0;
        end
        else if (gate[0] & ~clk_prev)
        begin
          next_q = gate[1] & gate[3];
        end
      end
      MODE_JK_R:
      begin
        if (gate[2])
        begin
          next_q = 1'b0;
        end
        else if (gate[0] & ~clk_prev)
        begin
          next_q = (gate[1] & ~q) | (~gate[3] & q);
        end
      end
      default:
      begin
        if (gate[2])
        begin
          next_q = 1'b0;
        end
        else if (gate[3])
        begin
          next_q = 1'b1;
        end
        else if (~gate[0])
        begin
          next_q = gate[1];
        end
      end
    endcase
    if (!ctl_en)
    begin
      next_q = 1'b0;
    end
    next_cell_out = ctl_en & (func ^ ctl_inv);
    next_flag = flag;
    if (cell_irq_flag_clear_in)
    begin
      next_flag = 1'b0;
    end
    // A detected edge wins over a clear in the same cycle.
    if ((ctl_rise & next_cell_out & ~cell_out) | (ctl_fall & ~next_cell_out & cell_out))
    begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      q <= 1'b0;
      clk_prev <= 1'b0;
      cell_out <= 1'b0;
      flag <= 1'b0;
    end
    else
    begin
      q <= next_q;
      clk_prev <= next_clk_prev;
      cell_out <= next_cell_out;
      flag <= next_flag;
    end
  end

  assign first_cell_output_out = cell_out;
  assign cell_irq_flag_out = flag;
endmodule
`default_nettype wire

// ===== plc_pkg.sv
/*
  Shared constants for the programmable logic cell: source selection
  codes, gate enable layout, function mode codes and reset values.
  Assumes a single 20 MHz clock domain around the cell.
*/
`default_nettype none
package plc_pkg;
  localparam int NUM_SOURCES = 41;
  localparam int SEL_W = 6;
  localparam int NUM_GATES = 4;
  localparam int GATE_EN_W = 8;
  // Each gate has bit 2*d for input d true and bit 2*d+1 for input d complemented.
  localparam int GATE_TRUE_POS = 0;
  localparam int GATE_COMP_POS = 1;
  localparam logic [SEL_W-1:0] SEL_OWN_OUTPUT = 6'h04;
  localparam logic [SEL_W-1:0] SEL_RESERVED_A = 6'h06;
  localparam logic [SEL_W-1:0] SEL_RESERVED_B = 6'h07;
  localparam logic [SEL_W-1:0] SEL_LAST = 6'h28;
  localparam logic [2:0] MODE_AND_OR = 3'h0;
  localparam logic [2:0] MODE_OR_XOR = 3'h1;
  localparam logic [2:0] MODE_AND4 = 3'h2;
  localparam logic [2:0] MODE_SR_LATCH = 3'h3;
  localparam logic [2:0] MODE_DFF_SR = 3'h4;
  localparam logic [2:0] MODE_DFF2_R = 3'h5;
  localparam logic [2:0] MODE_JK_R = 3'h6;
  localparam logic [2:0] MODE_DLATCH_SR = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic CTRL_BIT_RESET = 1'b0;
endpackage
`default_nettype wire

// ===== plc_cell_unused.sv
/*
  Holds no logic: the whole cell lives in plc_cell.sv.
  Assumes nothing of its surroundings.
*/

// ===== plc_src_model.sv
/*
  Far-side model of the pins and peripherals that feed the cell sources.
  Assumes the bench sets the levels and loops the cell output back.
*/
`default_nettype none
module plc_src_model
  import plc_pkg::*;
(
  input wire logic [NUM_SOURCES-1:0] level_in,
  input wire logic own_in,
  output logic [NUM_SOURCES-1:0] source_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Source four carries the cell's own output; the cell's selection code 4 reads its own output register, not this source.
  always_comb
  begin
    source_out = level_in;
    source_out[4] = own_in;
  end
endmodule
`default_nettype wire

// ===== plc_cell_assertions.sv
/*
  Checker on the cell output and its edge flag.
  Assumes it is bound to plc_cell and sees only its ports.
*/
`default_nettype none
module plc_cell_assertions
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cell_enable_bit_in,
  input wire logic cell_output_invert_in,
  input wire logic rise_irq_enable_in,
  input wire logic fall_irq_enable_in,
  input wire logic cell_irq_flag_clear_in,
  input wire logic first_cell_output_out,
  input wire logic cell_irq_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire o = first_cell_output_out;
  wire f = cell_irq_flag_out;
  wire re = rise_irq_enable_in;
  wire fe = fall_irq_enable_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_off; !cell_enable_bit_in |-> ##2 !o; endproperty
  a_off: assert property (p_off) else $error("output high while off");
  property p_on; $rose(o) |-> $past(cell_enable_bit_in, 2); endproperty
  a_on: assert property (p_on) else $error("output rose while off");
  property p_rise; $rose(o) && $past(re, 2) |-> f; endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_fall; $fell(o) && $past(fe, 2) |-> f; endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  property p_cause; $rose(f) |-> $rose(o) && $past(re, 2) || $fell(o) && $past(fe, 2); endproperty
  a_cause: assert property (p_cause) else $error("flag without edge");
  property p_hold; f && !cell_irq_flag_clear_in |=> f; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_clr; cell_irq_flag_clear_in && !$past(re) && !$past(fe) |=> !f; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_rst; $rose(reset_n_in) |-> !o && !f; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  c_flag: cover property ($rose(f));
  c_pol: cover property (cell_enable_bit_in && $changed(cell_output_invert_in));
  c_fall: cover property ($fell(o) && f);
endmodule
bind plc_cell plc_cell_assertions u_chk (.clk_in, .reset_n_in, .cell_enable_bit_in, .cell_output_invert_in,
  .rise_irq_enable_in, .fall_irq_enable_in, .cell_irq_flag_clear_in, .first_cell_output_out, .cell_irq_flag_out);
`default_nettype wire

// ===== configurable_logic_cell_tb.sv
/*
  Self-checking bench for the programmable logic cell.
  Assumes the cell, its checker and the source model are compiled first.
*/
`default_nettype none
`define CHK(n, e, a) chk(n, e, a)
module configurable_logic_cell_tb
  import plc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [23:0] sel;
    logic [31:0] gl;
    logic [3:0] gp;
    logic [2:0] md;
    logic inv;
    logic [40:0] src;
    logic exp;
  } plc_row_t;
  localparam logic [23:0] S = 24'h0c_2040;
  localparam logic [31:0] G = 32'h4010_0401;
  logic clk_in = 1'h0, reset_n = 1'h0, inv = 1'h0, en = 1'h0, re = 1'h0, fe = 1'h0, cl = 1'h0;
  logic [23:0] sel = S;
  logic [31:0] gl = G;
  logic [3:0] gp = 4'hf;
  logic [2:0] md = 3'h0;
  logic [40:0] lvl = 41'h0;
  logic [40:0] src;
  logic out, flag;
  int err_count = 0, n_checks = 0, k;
  plc_row_t rows [18] = '{
    '{S, G, 4'hf, 3'h2, 1'h0, 41'hf, 1'h1}, '{S, 32'h55, 4'hf, 3'h2, 1'h0, 41'hf, 1'h1},
    '{S, 32'h55, 4'he, 3'h2, 1'h0, 41'hf, 1'h0}, '{S, 32'haa, 4'hf, 3'h2, 1'h0, 41'h0, 1'h1},
    '{S, 32'haa, 4'he, 3'h2, 1'h0, 41'h0, 1'h0}, '{S, 32'h0, 4'he, 3'h2, 1'h0, 41'hf, 1'h0},
    '{S, 32'h0, 4'hf, 3'h2, 1'h0, 41'h0, 1'h1}, '{S, 32'h3, 4'hf, 3'h2, 1'h0, 41'h1, 1'h0},
    '{S, G, 4'hf, 3'h2, 1'h1, 41'hf, 1'h0}, '{S, G, 4'hf, 3'h0, 1'h0, 41'hc, 1'h1},
    '{S, G, 4'hf, 3'h0, 1'h0, 41'h5, 1'h0}, '{S, G, 4'hf, 3'h1, 1'h0, 41'h1, 1'h1},
    '{24'h21_0828, G, 4'hf, 3'h2, 1'h0, 41'h101_0001_0100, 1'h1}, '{24'h0c_2046, G, 4'hf, 3'h2, 1'h0, 41'h4f, 1'h0},
    '{S, G, 4'hf, 3'h3, 1'h0, 41'h1, 1'h1}, '{S, G, 4'hf, 3'h3, 1'h0, 41'h5, 1'h0},
    '{S, G, 4'hf, 3'h7, 1'h0, 41'h2, 1'h1}, '{24'h0c_2069, G, 4'hf, 3'h2, 1'h0, 41'h1ff_ffff_ffff, 1'h0}};
  plc_src_model u_src (.level_in(lvl), .own_in(out), .source_out(src));
  plc_cell u_dut (.clk_in(clk_in), .reset_n_in(reset_n), .source_in(src),
    .input_mux_select0_in(sel[5:0]), .input_mux_select1_in(sel[11:6]),
    .input_mux_select2_in(sel[17:12]), .input_mux_select3_in(sel[23:18]),
    .gate1_input_enables_in(gl[7:0]), .gate2_input_enables_in(gl[15:8]),
    .gate3_input_enables_in(gl[23:16]), .gate4_input_enables_in(gl[31:24]),
    .gate_output_invert_in(gp), .cell_output_invert_in(inv), .cell_enable_bit_in(en),
    .function_mode_field_in(md), .rise_irq_enable_in(re), .fall_irq_enable_in(fe),
    .cell_irq_flag_clear_in(cl), .first_cell_output_out(out), .cell_irq_flag_out(flag));
  always #25 clk_in = ~clk_in;
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string n, input logic e, input logic a);
    n_checks++;
    if (a !== e)
    begin
      $display("[FAIL] %s expected %b seen %b", n, e, a);
      err_count++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The cell is disabled while it is reconfigured and enabled afterwards.
  task automatic drive(input plc_row_t r);
    en = 1'h0;
    sel = r.sel;
    gl = r.gl;
    gp = r.gp;
    md = r.md;
    inv = r.inv;
    lvl = r.src;
    step(1);
    en = 1'h1;
    step(8);
  endtask
  initial
  begin
    step(4);
    reset_n = 1'h1;
    step(1);
    `CHK("reset out", 1'h0, out);
    for (int i = 0; i < 18; i++)
    begin
      drive(rows[i]);
      `CHK("row out", rows[i].exp, out);
    end
    re = 1'h1;
    cl = 1'h1;
    step(3);
    cl = 1'h0;
    inv = 1'h1;
    for (k = 0; k < 10 && flag !== 1'h1; k++)
      step(1);
    if (k == 10)
    begin
      err_count++;
      test_done();
    end
    step(4);
    `CHK("flag held", 1'h1, flag);
    cl = 1'h1;
    step(1);
    cl = 1'h0;
    step(2);
    `CHK("flag clear", 1'h0, flag);
    inv = 1'h0;
    step(6);
    `CHK("fall masked", 1'h0, flag);
    re = 1'h0;
    fe = 1'h1;
    inv = 1'h1;
    step(4);
    `CHK("rise masked", 1'h0, flag);
    inv = 1'h0;
    step(1);
    cl = 1'h1;
    step(1);
    cl = 1'h0;
    step(2);
    `CHK("fall beats clear", 1'h1, flag);
    inv = 1'h1;
    en = 1'h0;
    step(4);
    `CHK("disabled", 1'h0, out);
    drive('{S, 32'h401, 4'h3, MODE_DFF_SR, 1'h0, 41'h2, 1'h0});
    lvl = 41'h3;
    step(8);
    `CHK("dff load", 1'h1, out);
    lvl = 41'h0;
    step(8);
    `CHK("dff hold", 1'h1, out);
    drive('{S, 32'h4000_0401, 4'hb, MODE_DFF2_R, 1'h0, 41'h0, 1'h0});
    lvl = 41'h3;
    step(8);
    `CHK("dff2 gated", 1'h0, out);
    lvl = 41'h0;
    step(8);
    lvl = 41'hb;
    step(8);
    `CHK("dff2 load", 1'h1, out);
    drive('{S, 32'h4000_0401, 4'hb, MODE_JK_R, 1'h0, 41'h0, 1'h0});
    lvl = 41'h3;
    step(8);
    `CHK("jk set", 1'h1, out);
    lvl = 41'h0;
    step(8);
    lvl = 41'hb;
    step(8);
    `CHK("jk toggle", 1'h0, out);
    drive('{24'h0c_2044, 32'h0010_0001, 4'hf, MODE_AND_OR, 1'h0, 41'h4, 1'h0});
    `CHK("feedback set", 1'h1, out);
    lvl = 41'h0;
    step(8);
    `CHK("feedback hold", 1'h1, out);
    reset_n = 1'h0;
    step(1);
    `CHK("mid reset", 1'h0, out);
    `CHK("mid reset flag", 1'h0, flag);
    reset_n = 1'h1;
    step(4);
    `CHK("after reset", 1'h0, out);
    test_done();
  end
endmodule
`default_nettype wire
